//--- cpld_pkg.sv
package cpld_pkg;
  localparam int NUM_MC = 32;
  localparam int NUM_IO = 32;
  localparam int NUM_DED = 4;
  localparam int NUM_PT = 5;
  localparam int NUM_BLOCK = 2;
  localparam int SM_WIDTH = 40;
  localparam int GB_WIDTH = 68;
  localparam int PT_IN = 44;
  localparam int MC_PER_REGION = 4;
  localparam int MC_PER_CHAIN = 8;
  localparam int MC_PER_BLOCK = 16;
  localparam int PT_WORDS = 4;
  localparam int CTRL_A_WORD = 20;
  localparam int CTRL_B_WORD = 21;
  localparam logic [4:0] MC_WORDS = 5'h16;
  localparam logic [5:0] SM_SEL_END = 6'h28;
  localparam logic [6:0] GB_LAST = 7'h43;
  // byte addresses
  localparam logic [15:0] SW_BASE = 16'h1000;
  localparam logic [15:0] SIG_ADDR = 16'h1400;
  localparam logic [15:0] FUSE_ADDR = 16'h1404;
  localparam logic [15:0] STATE_ADDR = 16'h1408;
  localparam logic [15:0] PIN_ADDR = 16'h140C;
  // decode kinds
  localparam logic [2:0] K_NONE = 3'h0;
  localparam logic [2:0] K_MC = 3'h1;
  localparam logic [2:0] K_SW = 3'h2;
  localparam logic [2:0] K_SIG = 3'h3;
  localparam logic [2:0] K_FUSE = 3'h4;
  localparam logic [2:0] K_STATE = 3'h5;
  localparam logic [2:0] K_PIN = 3'h6;
  // field codes
  localparam logic [1:0] XOR_HIGH = 2'h1;
  localparam logic [1:0] XOR_PT = 2'h2;
  localparam logic [1:0] DATA_PT = 2'h1;
  localparam logic [1:0] DATA_PIN = 2'h2;
  localparam logic [2:0] FF_T = 3'h1;
  localparam logic [2:0] FF_JK = 3'h2;
  localparam logic [2:0] FF_SR = 3'h3;
  localparam logic [2:0] FF_LATCH = 3'h4;
  localparam logic [1:0] CLK_PT = 2'h3;
  localparam logic [1:0] CLR_GLOBAL = 2'h1;
  localparam logic [1:0] CLR_PT = 2'h2;
  localparam logic [1:0] CLR_BOTH = 2'h3;
  localparam logic [2:0] OE_OFF = 3'h0;
  localparam logic [2:0] OE_ON = 3'h1;
  localparam logic [2:0] OE_DED = 3'h2;
  localparam logic [2:0] OE_DED_N = 3'h3;
  localparam logic [2:0] OE_IO = 3'h4;
  localparam logic [2:0] OE_IO_N = 3'h5;
  localparam logic [2:0] OE_MC = 3'h6;
  localparam logic [2:0] OE_MC_N = 3'h7;
  typedef logic [31:0] word_t;
  typedef struct packed {
    logic [5:0] spare; logic [2:0] foldPt; logic clrWins; logic casEn;
    logic [2:0] ffMode; logic [1:0] dataSel; logic [2:0] dataPt;
    logic [1:0] xorSel; logic [2:0] xorPt; logic [2:0] auxPt; logic [4:0] orMask;
  } ctrl_a_t;
  typedef struct packed {
    logic spare; logic [1:0] clkSel; logic [2:0] clkPt; logic ceEn; logic [2:0] cePt;
    logic [1:0] clrSel; logic [2:0] clrPt; logic [1:0] clrPin; logic preEn;
    logic [2:0] prePt; logic outReg; logic fbReg; logic outInv;
    logic [2:0] oeSel; logic [4:0] oeIdx;
  } ctrl_b_t;
  typedef struct packed {
    logic [2:0] kind; logic [4:0] mc; logic [4:0] word; logic blk; logic [5:0] sel;
  } dec_t;
endpackage

//--- cpld_links.sv
interface cfg_if;
  logic valid;
  logic write;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport port(output valid, write, addr, wdata, input rdata);
  modport regs(input valid, write, addr, wdata, output rdata);
endinterface

interface bank_if;
  logic [cpld_pkg::NUM_MC-1:0] d, aux, clkIn, ceOk, clr, pre, clrWins, q;
  logic [cpld_pkg::NUM_MC-1:0][2:0] mode;
  modport core(output d, aux, clkIn, ceOk, clr, pre, clrWins, mode, input q);
  modport cells(input d, aux, clkIn, ceOk, clr, pre, clrWins, mode, output q);
endinterface

//--- ahb_cfg_port.sv
module ahb_cfg_port (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // register side
  cfg_if.port cfg
);
  import cpld_pkg::*;
  typedef struct packed {
    logic pend; logic write; logic [31:0] addr; logic ready; logic resp; logic [31:0] rdata;
  } port_st_t;
  port_st_t st, next_st;
  logic take;

  always_comb begin
    next_st = st;
    next_st.pend = 1'b0;
    take = hsel && htrans[1] && hready && st.ready;
    if (st.pend) begin
      next_st.ready = 1'b1;
      if (!st.write) next_st.rdata = cfg.rdata;
    end else if (take) begin
      next_st.pend = 1'b1;
      next_st.write = hwrite;
      next_st.addr = haddr;
      next_st.ready = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
      st.ready <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign cfg.valid = st.pend;
  assign cfg.write = st.write;
  assign cfg.addr = st.addr;
  assign cfg.wdata = hwdata;
  assign hreadyout = st.ready;
  assign hrdata = st.rdata;
  assign hresp = st.resp;

  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence s_accept; take && !st.pend; endsequence
  sequence s_one_wait; !hreadyout ##1 hreadyout; endsequence
  a_bus_wait_state: assert property (s_accept |=> s_one_wait)
    else $error("transfer did not complete after one wait state");
endmodule

//--- storage_bank.sv
module storage_bank (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // cell controls
  bank_if.cells bank
);
  import cpld_pkg::*;
  typedef struct packed {
    logic [NUM_MC-1:0] q;
    logic [NUM_MC-1:0] clkPrev;
  } bank_st_t;
  bank_st_t st, next_st;
  logic [NUM_MC-1:0] rise;

  always_comb begin
    next_st = st;
    rise = '0;
    for (int m = 0; m < NUM_MC; m++) begin
      rise[m] = bank.clkIn[m] & ~st.clkPrev[m] & bank.ceOk[m];
      next_st.clkPrev[m] = bank.clkIn[m];
      if (bank.mode[m] == FF_LATCH) begin
        if (bank.clkIn[m]) next_st.q[m] = bank.d[m];
      end else if (rise[m]) begin
        case (bank.mode[m])
          FF_T: next_st.q[m] = st.q[m] ^ bank.d[m];
          FF_JK: next_st.q[m] = (bank.d[m] & ~st.q[m]) | (~bank.aux[m] & st.q[m]);
          FF_SR: next_st.q[m] = bank.d[m] | (~bank.aux[m] & st.q[m]);
          default: next_st.q[m] = bank.d[m];
        endcase
      end
      if (bank.clr[m] && bank.pre[m]) next_st.q[m] = ~bank.clrWins[m];
      else if (bank.clr[m]) next_st.q[m] = 1'b0;
      else if (bank.pre[m]) next_st.q[m] = 1'b1;
    end
  end

  // registers start cleared
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) st <= '0;
    else st <= next_st;
  end

  assign bank.q = st.q;

  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic quiet0;
  assign quiet0 = !bank.clr[0] && !bank.pre[0];
  sequence s_clr_held; (bank.clr[0] && !bank.pre[0]) [*3]; endsequence
  a_edge_d_capture: assert property (rise[0] && bank.mode[0] == 3'h0 && quiet0
    |=> bank.q[0] == $past(bank.d[0])) else $error("d capture on rising edge failed");
  a_no_edge_hold: assert property (!rise[0] && bank.mode[0] != FF_LATCH && quiet0
    |=> $stable(bank.q[0])) else $error("state changed without enabled edge");
  a_latch_passes: assert property (bank.mode[0] == FF_LATCH && bank.clkIn[0] && quiet0
    |=> bank.q[0] == $past(bank.d[0])) else $error("latch not transparent");
  a_toggle_flips: assert property (rise[0] && bank.mode[0] == FF_T && bank.d[0] && quiet0
    |=> bank.q[0] != $past(bank.q[0])) else $error("toggle did not flip");
  a_clear_held: assert property (s_clr_held |-> !bank.q[0])
    else $error("clear did not hold the cell low");
  a_preset_sets: assert property (bank.pre[0] && !bank.clr[0] |=> bank.q[0])
    else $error("preset did not set the cell");
  a_both_resolve: assert property (bank.pre[0] && bank.clr[0]
    |=> bank.q[0] == !$past(bank.clrWins[0])) else $error("clear and preset resolved wrongly");
endmodule

//--- cpld_core.sv
// Contract
// - five product terms over global and regional inputs
// - allocator routes terms to sum or controls
// - four cascade chains of eight macrocells
// - xor takes sum and term or constant
// - constant xor input sets polarity
// - xor path gives toggle and jk behaviour
// - data from xor, term or pin
// - cell runs as d, t, jk or sr
// - latch passes when clock high, holds low
// - clock from three global lines or term
// - flip-flop updates on rising edge only
// - low enable term ignores global clock edges
// - clear: global, term, both or off
// - preset: term or off
// - output and feedback each registered or combinatorial
// - io direction and enable source selectable
// - input pins keep macrocell logic usable
// - global bus feeds forty-wide switch matrices
// - inverted foldback term shared in region
// - dedicated pins act as clock, clear, enable
// - signature readable despite security fuse
// - reset initialises cells and outputs
//
// Implementation choices: the placing of the registers and the AHB-Lite register port.
module cpld_core (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // ahb-lite register bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // device pins
  input wire logic [cpld_pkg::NUM_DED-1:0] dedPin,
  input wire logic [cpld_pkg::NUM_IO-1:0] ioIn,
  output logic [cpld_pkg::NUM_IO-1:0] ioOut,
  output logic [cpld_pkg::NUM_IO-1:0] ioOeN
);
  import cpld_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [NUM_DED-1:0] dedMeta;
    logic [NUM_DED-1:0] dedSync;
    logic [NUM_IO-1:0] ioMeta;
    logic [NUM_IO-1:0] ioSync;
    logic [NUM_MC-1:0] combFb;
    logic [NUM_MC-1:0] foldFb;
    logic [NUM_MC-1:0] pinOut;
    logic [NUM_MC-1:0] pinOeN;
    logic fuse;
    logic [15:0] sig;
  } core_st_t;
  core_st_t st, next_st;

  word_t cfgMem [NUM_MC][MC_WORDS];
  logic [6:0] swMem [NUM_BLOCK][SM_WIDTH];
  logic [NUM_PT-1:0] pt [NUM_MC];
  logic [SM_WIDTH-1:0] sm [NUM_BLOCK];
  logic [GB_WIDTH-1:0] gb;
  logic [PT_IN-1:0] ptIn;
  logic [NUM_MC-1:0] sum, xo, cascade_input, fbBus;
  logic xorIn, gclr, oeRaw, cfgWr;
  ctrl_a_t ca, ca0;
  ctrl_b_t cb, cb0;
  dec_t dec;

  cfg_if cfg();
  bank_if bank();

  ////////////////////////////////////////////////////////////////////////////
  ahb_cfg_port port (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hrdata(hrdata),
    .hresp(hresp),
    .cfg(cfg)
  );

  storage_bank cells (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .bank(bank)
  );

  ////////////////////////////////////////////////////////////////////////////
  // product term: and of selected true and complement inputs
  function automatic logic pt_eval(input logic [PT_IN-1:0] tm, input logic [PT_IN-1:0] cm,
                                   input logic [PT_IN-1:0] x);
    pt_eval = |(tm | cm) && &(~tm | x) && &(~cm | ~x);
  endfunction

  // pick one of the five terms, out of range reads low
  function automatic logic pick(input logic [NUM_PT-1:0] terms, input logic [2:0] idx);
    pick = (idx < 3'h5) ? terms[idx] : 1'b0;
  endfunction

  function automatic dec_t decode(input logic [31:0] a);
    dec_t r;
    r = '0;
    r.mc = a[11:7];
    r.word = a[6:2];
    r.blk = a[8];
    r.sel = a[7:2];
    if (a[31:16] != 16'h0 || a[1:0] != 2'h0) begin
      r.kind = K_NONE;
    end else if (a[15:12] == 4'h0 && a[6:2] < MC_WORDS) begin
      r.kind = K_MC;
    end else if (a[15:9] == SW_BASE[15:9] && a[7:2] < SM_SEL_END) begin
      r.kind = K_SW;
    end else if (a[15:0] == SIG_ADDR) begin
      r.kind = K_SIG;
    end else if (a[15:0] == FUSE_ADDR) begin
      r.kind = K_FUSE;
    end else if (a[15:0] == STATE_ADDR) begin
      r.kind = K_STATE;
    end else if (a[15:0] == PIN_ADDR) begin
      r.kind = K_PIN;
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // configuration memory
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int m = 0; m < NUM_MC; m++) begin
        for (int w = 0; w < MC_WORDS; w++) begin
          cfgMem[m][w] <= '0;
        end
      end
      for (int b = 0; b < NUM_BLOCK; b++) begin
        for (int k = 0; k < SM_WIDTH; k++) begin
          swMem[b][k] <= '0;
        end
      end
    end else if (cfgWr) begin
      if (dec.kind == K_MC) cfgMem[dec.mc][dec.word] <= cfg.wdata;
      else if (dec.kind == K_SW) swMem[dec.blk][dec.sel] <= cfg.wdata[6:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st = st;
    ptIn = '0;
    xorIn = 1'b0;
    gclr = 1'b0;
    oeRaw = 1'b0;
    ca = '0;
    cb = '0;
    // two-stage pin synchronisers
    next_st.dedMeta = dedPin;
    next_st.dedSync = st.dedMeta;
    next_st.ioMeta = ioIn;
    next_st.ioSync = st.ioMeta;
    // buried feedback per macrocell
    for (int m = 0; m < NUM_MC; m++) begin
      cb = cfgMem[m][CTRL_B_WORD];
      fbBus[m] = cb.fbReg ? bank.q[m] : st.combFb[m];
    end
    gb = {fbBus, st.ioSync, st.dedSync};
    for (int b = 0; b < NUM_BLOCK; b++) begin
      for (int k = 0; k < SM_WIDTH; k++) begin
        sm[b][k] = (swMem[b][k] <= GB_LAST) ? gb[swMem[b][k]] : 1'b0;
      end
    end
    for (int m = 0; m < NUM_MC; m++) begin
      ca = cfgMem[m][CTRL_A_WORD];
      cb = cfgMem[m][CTRL_B_WORD];
      ptIn = {st.foldFb[(m / MC_PER_REGION) * MC_PER_REGION +: MC_PER_REGION],
              sm[m / MC_PER_BLOCK]};
      for (int p = 0; p < NUM_PT; p++) begin
        pt[m][p] = pt_eval({cfgMem[m][PT_WORDS * p + 1][PT_IN-33:0],
                            cfgMem[m][PT_WORDS * p]},
                           {cfgMem[m][PT_WORDS * p + 3][PT_IN-33:0],
                            cfgMem[m][PT_WORDS * p + 2]}, ptIn);
      end
      // cascade from the previous macrocell in the chain
      cascade_input[m] = 1'b0;
      if (m % MC_PER_CHAIN != 0) cascade_input[m] = sum[m - 1];
      sum[m] = |(pt[m] & ca.orMask) | (ca.casEn & cascade_input[m]);
      case (ca.xorSel)
        XOR_HIGH: xorIn = 1'b1;
        XOR_PT: xorIn = pick(pt[m], ca.xorPt);
        default: xorIn = 1'b0;
      endcase
      xo[m] = sum[m] ^ xorIn;
      case (ca.dataSel)
        DATA_PT: bank.d[m] = pick(pt[m], ca.dataPt);
        DATA_PIN: bank.d[m] = st.ioSync[m];
        default: bank.d[m] = xo[m];
      endcase
      bank.aux[m] = pick(pt[m], ca.auxPt);
      bank.mode[m] = ca.ffMode;
      bank.clrWins[m] = ca.clrWins;
      // clock, enable, clear and preset selection
      if (cb.clkSel == CLK_PT) bank.clkIn[m] = pick(pt[m], cb.clkPt);
      else bank.clkIn[m] = st.dedSync[cb.clkSel];
      bank.ceOk[m] = !(cb.ceEn && cb.clkSel != CLK_PT) || pick(pt[m], cb.cePt);
      gclr = st.dedSync[cb.clrPin];
      case (cb.clrSel)
        CLR_GLOBAL: bank.clr[m] = gclr;
        CLR_PT: bank.clr[m] = pick(pt[m], cb.clrPt);
        CLR_BOTH: bank.clr[m] = gclr | pick(pt[m], cb.clrPt);
        default: bank.clr[m] = 1'b0;
      endcase
      bank.pre[m] = cb.preEn & pick(pt[m], cb.prePt);
      next_st.combFb[m] = xo[m];
      next_st.foldFb[m] = ~pick(pt[m], ca.foldPt);
      next_st.pinOut[m] = (cb.outReg ? bank.q[m] : xo[m]) ^ cb.outInv;
      case (cb.oeSel)
        OE_ON: oeRaw = 1'b1;
        OE_DED: oeRaw = st.dedSync[cb.oeIdx[1:0]];
        OE_DED_N: oeRaw = ~st.dedSync[cb.oeIdx[1:0]];
        OE_IO: oeRaw = st.ioSync[cb.oeIdx];
        OE_IO_N: oeRaw = ~st.ioSync[cb.oeIdx];
        OE_MC: oeRaw = fbBus[cb.oeIdx];
        OE_MC_N: oeRaw = ~fbBus[cb.oeIdx];
        default: oeRaw = 1'b0;
      endcase
      next_st.pinOeN[m] = ~oeRaw;
    end
    // register access
    dec = decode(cfg.addr);
    cfgWr = cfg.valid && cfg.write;
    cfg.rdata = '0;
    if (dec.kind == K_MC && !st.fuse) begin
      cfg.rdata = cfgMem[dec.mc][dec.word];
    end else if (dec.kind == K_SW && !st.fuse) begin
      cfg.rdata = {25'h0, swMem[dec.blk][dec.sel]};
    end else if (dec.kind == K_SIG) begin
      cfg.rdata = {16'h0, st.sig};
    end else if (dec.kind == K_FUSE) begin
      cfg.rdata = {31'h0, st.fuse};
    end else if (dec.kind == K_STATE) begin
      cfg.rdata = bank.q;
    end else if (dec.kind == K_PIN) begin
      cfg.rdata = st.ioSync;
    end
    if (cfgWr && dec.kind == K_SIG) next_st.sig = cfg.wdata[15:0];
    if (cfgWr && dec.kind == K_FUSE && cfg.wdata[0]) next_st.fuse = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs released, not driven, out of reset
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
      st.pinOeN <= '1;
    end else begin
      st <= next_st;
    end
  end

  assign ioOut = st.pinOut;
  assign ioOeN = st.pinOeN;

  ////////////////////////////////////////////////////////////////////////////
  // checks on macrocell zero and on signature and fuse reads
  assign ca0 = cfgMem[0][CTRL_A_WORD];
  assign cb0 = cfgMem[0][CTRL_B_WORD];
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence s_read(logic [2:0] k); cfg.valid && !cfg.write && dec.kind == k; endsequence
  a_or_full_sum: assert property (ca0.orMask == 5'h1F && !ca0.casEn |-> sum[0] == |pt[0])
    else $error("five-term sum wrong");
  a_cascade_link: assert property (ca0.casEn && ca0.orMask == 5'h0 && sum[0] == 1'b0
    |-> cascade_input[1] == sum[0]) else $error("cascade input not from neighbour");
  a_xor_invert: assert property (ca0.xorSel == XOR_HIGH |-> xo[0] == ~sum[0])
    else $error("polarity constant not applied");
  a_data_from_pin: assert property (ca0.dataSel == DATA_PIN |-> bank.d[0] == st.ioSync[0])
    else $error("data not taken from pin");
  a_clk_global: assert property (cb0.clkSel == 2'h1 |-> bank.clkIn[0] == st.dedSync[1])
    else $error("global clock line not selected");
  a_clear_both: assert property (cb0.clrSel == CLR_BOTH
    |-> bank.clr[0] == (st.dedSync[cb0.clrPin] | pick(pt[0], cb0.clrPt)))
    else $error("clear or-combination wrong");
  a_comb_output: assert property (!cb0.outReg ##1 !cb0.outReg
    |-> ioOut[0] == $past(xo[0] ^ cb0.outInv)) else $error("combinatorial output wrong");
  a_oe_input_only: assert property (cb0.oeSel == OE_OFF |=> ioOeN[0])
    else $error("input-only pin driven");
  a_fold_inverse: assert property (!sys_rst |=> st.foldFb[0] == !$past(pick(pt[0], ca0.foldPt)))
    else $error("foldback not inverse of term");
  a_sig_readable: assert property (s_read(K_SIG) |=> hrdata == {16'h0, $past(st.sig)})
    else $error("signature not readable");
  a_fuse_hides: assert property (s_read(K_MC) && st.fuse |=> hrdata == 32'h0)
    else $error("protected configuration visible");
endmodule

//--- board_model.sv
module board_model (
  // clock
  input wire logic core_clk,
  // device side of the pins
  input wire logic [cpld_pkg::NUM_IO-1:0] ioOut,
  input wire logic [cpld_pkg::NUM_IO-1:0] ioOeN,
  // board drivers
  input wire logic [cpld_pkg::NUM_IO-1:0] boardEn,
  input wire logic [cpld_pkg::NUM_IO-1:0] boardVal,
  // resolved wire levels
  output logic [cpld_pkg::NUM_IO-1:0] ioIn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [cpld_pkg::NUM_IO-1:0] floatLvl = '0;
  ////////////////////////////////////////////////////////////////////////////
  // undriven wires wander every cycle, no keeper assumed
  always @(posedge core_clk) begin
    floatLvl <= ~floatLvl;
  end
  // device drive first, then board, else floating level
  always_comb begin
    for (int m = 0; m < cpld_pkg::NUM_IO; m++) begin
      ioIn[m] = !ioOeN[m] ? ioOut[m] : (boardEn[m] ? boardVal[m] : floatLvl[m]);
    end
  end
endmodule

//--- tb_cpld_core.sv
`define CHK(nm, exp, got) begin nTests++; if ((got) !== (exp)) begin failures++; \
  $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end

module tb_cpld_core import cpld_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, sys_rst, hsel, hwrite, hready, hreadyout, hresp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rdVal;
  logic [NUM_DED-1:0] dedPin;
  logic [NUM_IO-1:0] ioIn, ioOut, ioOeN, boardEn, boardVal;
  int failures, nTests;
  ////////////////////////////////////////////////////////////////////////////
  assign hready = hreadyout;
  cpld_core DUT (.core_clk(core_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .dedPin(dedPin), .ioIn(ioIn),
    .ioOut(ioOut), .ioOeN(ioOeN));
  board_model board (.core_clk(core_clk), .ioOut(ioOut), .ioOeN(ioOeN), .boardEn(boardEn),
    .boardVal(boardVal), .ioIn(ioIn));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // one single word transfer, waits on hready at each phase
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge core_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge core_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    ahb(1'b1, a, d, rdVal);
    repeat (4) @(posedge core_clk);
  endtask
  task automatic rd(input logic [31:0] a);
    ahb(1'b0, a, 32'h0, rdVal);
  endtask
  // pin change plus time for sync, edge detect and output register
  task automatic pin(input int i, input logic v);
    dedPin[i] <= v;
    repeat (8) @(posedge core_clk);
  endtask
  task final_report();
    $display("comparisons %0d mismatches %0d", nTests, failures);
    if (failures == 0 && nTests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #50000;
    failures++;
    final_report();
  end
  initial begin
    failures = 0;
    nTests = 0;
    sys_rst = 1'b1;
    {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
    dedPin = '0;
    boardEn = 32'hFFFF0000;
    boardVal = 32'h00FF0000;
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    `CHK("oe after reset", 32'hFFFFFFFF, ioOeN)
    `CHK("out after reset", 32'h00000000, ioOut)
    // mc0: term 0 on switch output 0, which carries dedicated pin 3
    wr(SIG_ADDR, 32'h00001234);
    wr(SW_BASE, 32'h00000003);
    wr(32'h00000000, 32'h00000001);
    wr(32'h00000050, 32'h00000001);
    wr(32'h00000054, 32'h00000020);
    rd(32'h00000050);
    `CHK("ctrl a readback", 32'h00000001, rdVal)
    rd(32'h00000058);
    `CHK("unmapped word", 32'h00000000, rdVal)
    `CHK("oe forced on", 1'b0, ioOeN[0])
    `CHK("hresp", 1'b0, hresp)
    pin(3, 1'b1);
    `CHK("comb high", 1'b1, ioOut[0])
    pin(3, 1'b0);
    `CHK("comb low", 1'b0, ioOut[0])
    wr(32'h00000050, 32'h00000801);
    `CHK("polarity", 1'b1, ioOut[0])
    // registered d, global line 0, clear from dedicated pin 2
    wr(32'h00000050, 32'h00000001);
    wr(32'h00000054, 32'h00110420);
    pin(3, 1'b1);
    `CHK("no edge yet", 1'b0, ioOut[0])
    pin(0, 1'b1);
    `CHK("rising edge", 1'b1, ioOut[0])
    pin(0, 1'b0);
    pin(3, 1'b0);
    `CHK("falling holds", 1'b1, ioOut[0])
    pin(2, 1'b1);
    `CHK("global clear", 1'b0, ioOut[0])
    pin(2, 1'b0);
    // toggle mode with data held high
    wr(32'h00000050, 32'h00040001);
    pin(3, 1'b1);
    pin(0, 1'b1);
    `CHK("toggle one", 1'b1, ioOut[0])
    pin(0, 1'b0);
    pin(0, 1'b1);
    `CHK("toggle two", 1'b0, ioOut[0])
    // enable from disabled term 1 is low
    wr(32'h00000054, 32'h02510420);
    pin(0, 1'b0);
    pin(0, 1'b1);
    `CHK("enable low", 1'b0, ioOut[0])
    pin(0, 1'b0);
    // latch mode
    wr(32'h00000054, 32'h00110420);
    wr(32'h00000050, 32'h00100001);
    `CHK("latch closed", 1'b0, ioOut[0])
    pin(0, 1'b1);
    `CHK("latch open", 1'b1, ioOut[0])
    pin(3, 1'b0);
    `CHK("latch follows", 1'b0, ioOut[0])
    pin(0, 1'b0);
    pin(3, 1'b1);
    `CHK("latch holds", 1'b0, ioOut[0])
    rd(STATE_ADDR);
    `CHK("cell state", 1'b0, rdVal[0])
    // preset from term 0, dedicated pin 3 still high
    wr(32'h00000054, 32'h00114420);
    `CHK("preset", 1'b1, ioOut[0])
    // fuse hides config but not signature
    wr(FUSE_ADDR, 32'h00000001);
    rd(32'h00000050);
    `CHK("config hidden", 32'h00000000, rdVal)
    rd(SIG_ADDR);
    `CHK("signature", 32'h00001234, rdVal)
    final_report();
  end
endmodule
